// >>> ueb_pkg.sv
// Purpose: constants shared by the endpoint buffer control block
// Assumes: one clock i_mclk at 100 MHz, asynchronous active-high reset
// Notes: command codes are one byte, low nibble selects the endpoint
//
// What this block does
// - codes 40h..4Fh set the halt flag of the addressed endpoint, no data
// - codes 80h..8Fh clear the halt flag of the addressed endpoint, no data
// - stall and unstall act through the halt bit of the endpoint status
// - a SETUP token unstalls a halted control endpoint unless a stall command lands in the same cycle
// - leaving the halted state flushes the buffer and resets toggle to DATA0
// - codes 61h..6Fh mark the addressed IN buffer full and valid
// - a validated IN buffer goes out on the next IN token to that endpoint
// - on double-buffered endpoints validate and clear swap the firmware bank
// - codes 70h, 72h..7Fh empty and release an OUT buffer; 71h does nothing
// - a complete OUT packet sets the buffer-full flag of that endpoint
// - a full, unreleased OUT buffer answers further packets with NAK
// - codes D0h..DFh return a status copy and change no pending bit and no status bit but bit 3
// - status bit 7 shows the halt flag
// - status bit 6 shows second bank full, bit 5 first bank full
// - status bit 4 shows the data toggle expected next
// - bit 3 sets when a new setup replaces unacknowledged, unstalled setup
// - a D0h status read clears bit 3 only once setup storing has finished
// - status bit 2 shows that the buffer holds a setup packet
// - status bit 1 shows the firmware bank; bit 0 reads zero
// - the destructive read 50h..5Fh clears the endpoint pending bit
// - a setup blocks validate and clear on both control endpoints until F4h

package ueb_pkg;

    localparam int NUM_EP = 16;

    // ************************************************
    // command opcodes (upper nibble) and fixed codes
    // ************************************************
    localparam logic [3:0] OP_STALL = 4'h4;
    localparam logic [3:0] OP_DRAIN = 4'h5;
    localparam logic [3:0] OP_VALID = 4'h6;
    localparam logic [3:0] OP_CLEAR = 4'h7;
    localparam logic [3:0] OP_UNSTALL = 4'h8;
    localparam logic [3:0] OP_PEEK = 4'hD;
    localparam logic [7:0] CMD_ACK_SETUP = 8'hF4;
    localparam logic [3:0] EP_CTRL_OUT = 4'h0;
    localparam logic [3:0] EP_CTRL_IN = 4'h1;

    // ************************************************
    // status byte layout
    // ************************************************
    localparam int ST_HALT = 7;
    localparam int ST_FULL1 = 6;
    localparam int ST_FULL0 = 5;
    localparam int ST_TOGGLE = 4;
    localparam int ST_CLOBBER = 3;
    localparam int ST_SETUP = 2;
    localparam int ST_BANK = 1;
    localparam logic [7:0] STATUS_RST = 8'h00;

    // ************************************************
    // token kinds and handshake answers
    // ************************************************
    localparam logic [1:0] TOK_OUT = 2'h0;
    localparam logic [1:0] TOK_IN = 2'h1;
    localparam logic [1:0] TOK_SETUP = 2'h2;
    localparam logic [1:0] HS_ACK = 2'h0;
    localparam logic [1:0] HS_NAK = 2'h1;
    localparam logic [1:0] HS_STALL = 2'h2;
    localparam logic [1:0] HS_DATA = 2'h3;

    // ************************************************
    // pin synchroniser: {cs_n, wr_n, rd_n, a0, data[7:0]}
    // ************************************************
    localparam int PIN_W = 12;
    localparam logic [11:0] PIN_RST = 12'hE00;

endpackage

// >>> ueb_pin_sync.sv
// Purpose: three-stage synchroniser for the command port pins
// Assumes: pins are asynchronous to i_mclk
// Notes: a level is accepted only when stages two and three agree
`timescale 1ns/10ps

module ueb_pin_sync #(
    parameter int W = 12,
    parameter logic [11:0] RST = 12'h000
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_pin,
    output logic [W-1:0] o_level
);

    // ************************************************
    // per-bit chain
    // ************************************************
    genvar b;
    generate
        for (b = 0; b < W; b++) begin : g_bit
            logic s1_r;
            logic s2_r;
            logic s3_r;
            logic lvl_r;
            // s1 feeds only s2, so metastability never reaches the compare
            always_ff @(posedge i_mclk or posedge i_rst) begin
                if (i_rst) begin
                    s1_r <= RST[b];
                    s2_r <= RST[b];
                    s3_r <= RST[b];
                    lvl_r <= RST[b];
                end else begin
                    s1_r <= i_pin[b];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                    if (s2_r == s3_r) begin
                        lvl_r <= s3_r;
                    end
                end
            end
            assign o_level[b] = lvl_r;
        end
    endgenerate

endmodule

// >>> ueb_ep_ctrl.sv
// Purpose: command-driven stall, validate, clear and status control of 16 endpoints
// Assumes: usb-side event inputs come from logic on i_mclk
// Notes: command port pins are synchronised; strobe acts when wr_n rises
`timescale 1ns/10ps

module ueb_ep_ctrl (
    input wire logic i_mclk,
    input wire logic i_rst,
    // command/data port pins
    input wire logic i_cs_n,
    input wire logic i_wr_n,
    input wire logic i_rd_n,
    input wire logic i_a0,
    input wire logic [7:0] i_data,
    output logic [7:0] o_data,
    output logic o_data_oe_n,
    // double-buffer enables per endpoint
    input wire logic [15:0] i_dbl_buf,
    // usb side
    input wire logic i_tok_stb,
    input wire logic [1:0] i_tok_kind,
    input wire logic [3:0] i_tok_ep,
    input wire logic i_rx_ok,
    input wire logic i_tx_ack,
    input wire logic [3:0] i_evt_ep,
    input wire logic i_setup_done,
    output logic o_hs_valid,
    output logic [1:0] o_hs_code,
    output logic o_tx_bank,
    output logic [15:0] o_flush,
    output logic [15:0] o_int_pend,
    output logic o_setup_lock
);

    // ************************************************
    // pin capture and write strobe
    // ************************************************
    logic [11:0] pin_lvl;
    logic wr_n_prev_r;
    logic [7:0] rd_byte_r;
    logic oe_n_r;

    ueb_pin_sync #(
        .W(ueb_pkg::PIN_W),
        .RST(ueb_pkg::PIN_RST)
    ) u_sync (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_pin({i_cs_n, i_wr_n, i_rd_n, i_a0, i_data}),
        .o_level(pin_lvl)
    );

    wire cs_n_s = pin_lvl[11];
    wire wr_n_s = pin_lvl[10];
    wire rd_n_s = pin_lvl[9];
    wire a0_s = pin_lvl[8];
    wire [7:0] data_s = pin_lvl[7:0];

    // command taken on the rising edge of wr_n while selected and a0 high
    wire cmd_stb = wr_n_s & ~wr_n_prev_r & ~cs_n_s & a0_s;
    wire [3:0] cmd_op = data_s[7:4];
    wire [3:0] cmd_ep = data_s[3:0];
    wire ack_setup = cmd_stb & (data_s == ueb_pkg::CMD_ACK_SETUP);
    wire rd_drive = ~cs_n_s & ~rd_n_s & ~a0_s;

    // ************************************************
    // endpoint state
    // ************************************************
    logic [15:0] halt_r, full0_r, full1_r, tog_r, clob_r, setp_r, cbank_r, ubank_r, pend_r;
    logic [15:0] halt_nxt, full0_nxt, full1_nxt, tog_nxt, clob_nxt, setp_nxt;
    logic [15:0] cbank_nxt, ubank_nxt, pend_nxt, flush_v;
    logic [7:0] st_w [16];
    logic lock_r;
    logic setup_busy_r;

    wire setup_tok = i_tok_stb & (i_tok_kind == ueb_pkg::TOK_SETUP);

    genvar e;
    generate
        for (e = 0; e < ueb_pkg::NUM_EP; e++) begin : g_ep
            localparam logic [3:0] EP = 4'(e);
            localparam bit IS_CTRL = (e < 2);
            wire hit = cmd_stb & (cmd_ep == EP);
            wire blocked = IS_CTRL & lock_r;
            wire stall_hit = hit & (cmd_op == ueb_pkg::OP_STALL);
            wire unstall_hit = hit & (cmd_op == ueb_pkg::OP_UNSTALL);
            wire valid_hit = hit & (cmd_op == ueb_pkg::OP_VALID)
                & (EP != ueb_pkg::EP_CTRL_OUT) & ~blocked;
            wire clear_hit = hit & (cmd_op == ueb_pkg::OP_CLEAR)
                & (EP != ueb_pkg::EP_CTRL_IN) & ~blocked;
            wire peek_hit = hit & (cmd_op == ueb_pkg::OP_PEEK);
            wire drain_hit = hit & (cmd_op == ueb_pkg::OP_DRAIN);
            wire setup_here = setup_tok & IS_CTRL;
            wire evt_here = i_evt_ep == EP;
            wire rx_here = i_rx_ok & evt_here;
            wire tx_here = i_tx_ack & evt_here;
            wire dbl = i_dbl_buf[e];
            wire sdone = i_setup_done & (EP == ueb_pkg::EP_CTRL_OUT);
            // any way out of the halted state re-initialises the endpoint
            wire flush = halt_r[e] & (unstall_hit | setup_here);
            wire c_swap = (valid_hit | clear_hit) & dbl;
            wire u_swap = (rx_here | tx_here) & dbl;
            wire [1:0] clr_b = {(clear_hit & cbank_r[e]) | (tx_here & ubank_r[e]),
                                (clear_hit & ~cbank_r[e]) | (tx_here & ~ubank_r[e])};
            wire [1:0] set_b = {(valid_hit & cbank_r[e]) | (rx_here & ubank_r[e]),
                                (valid_hit & ~cbank_r[e]) | (rx_here & ~ubank_r[e]) | sdone};

            assign flush_v[e] = flush;
            // a re-stall in the cycle of a setup wins, so firmware keeps the halt
            assign halt_nxt[e] = stall_hit | (halt_r[e] & ~unstall_hit & ~setup_here);
            // sets are applied after clears, so a coinciding event is not lost
            assign full0_nxt[e] = (full0_r[e] & ~flush & ~clr_b[0]) | set_b[0];
            assign full1_nxt[e] = (full1_r[e] & ~flush & ~clr_b[1]) | set_b[1];
            assign tog_nxt[e] = flush ? 1'b0 : (tog_r[e] ^ (rx_here | tx_here));
            assign cbank_nxt[e] = flush ? 1'b0 : (cbank_r[e] ^ c_swap);
            assign ubank_nxt[e] = flush ? 1'b0 : (ubank_r[e] ^ u_swap);
            if (e == 0) begin : g_setup
                wire clob_set = setup_tok & setp_r[e] & lock_r & ~halt_r[e];
                wire clob_clr = peek_hit & ~setup_busy_r;
                assign clob_nxt[e] = clob_set | (clob_r[e] & ~clob_clr);
                assign setp_nxt[e] = setup_tok | (setp_r[e] & ~clear_hit);
            end else begin : g_plain
                assign clob_nxt[e] = 1'b0;
                assign setp_nxt[e] = 1'b0;
            end
            // the snapshot read leaves pending alone; only the destructive one clears
            assign pend_nxt[e] = rx_here | tx_here | (setup_tok & (e == 0))
                | (pend_r[e] & ~drain_hit);
            assign st_w[e] = {halt_r[e], full1_r[e], full0_r[e], tog_r[e],
                              clob_r[e], setp_r[e], cbank_r[e], 1'b0};
        end
    endgenerate

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            halt_r <= 16'h0000;
            full0_r <= 16'h0000;
            full1_r <= 16'h0000;
            tog_r <= 16'h0000;
            clob_r <= 16'h0000;
            setp_r <= 16'h0000;
            cbank_r <= 16'h0000;
            ubank_r <= 16'h0000;
            pend_r <= 16'h0000;
        end else begin
            halt_r <= halt_nxt;
            full0_r <= full0_nxt;
            full1_r <= full1_nxt;
            tog_r <= tog_nxt;
            clob_r <= clob_nxt;
            setp_r <= setp_nxt;
            cbank_r <= cbank_nxt;
            ubank_r <= ubank_nxt;
            pend_r <= pend_nxt;
        end
    end

    // ************************************************
    // setup lock and storing flag
    // ************************************************
    wire lock_nxt = setup_tok | (lock_r & ~ack_setup);
    wire busy_nxt = setup_tok | (setup_busy_r & ~i_setup_done);

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            lock_r <= 1'b0;
            setup_busy_r <= 1'b0;
        end else begin
            lock_r <= lock_nxt;
            setup_busy_r <= busy_nxt;
        end
    end

    // ************************************************
    // token answers
    // ************************************************
    wire [7:0] tok_st = st_w[i_tok_ep];
    wire tok_ubank = ubank_r[i_tok_ep];
    wire tok_full = tok_ubank ? tok_st[ueb_pkg::ST_FULL1] : tok_st[ueb_pkg::ST_FULL0];
    logic [1:0] hs_sel;
    always_comb begin
        if (i_tok_kind == ueb_pkg::TOK_SETUP) begin
            hs_sel = ueb_pkg::HS_ACK;
        end else if (tok_st[ueb_pkg::ST_HALT]) begin
            hs_sel = ueb_pkg::HS_STALL;
        end else if (i_tok_kind == ueb_pkg::TOK_IN) begin
            hs_sel = tok_full ? ueb_pkg::HS_DATA : ueb_pkg::HS_NAK;
        end else begin
            hs_sel = tok_full ? ueb_pkg::HS_NAK : ueb_pkg::HS_ACK;
        end
    end

    logic hs_valid_r;
    logic [1:0] hs_code_r;
    logic tx_bank_r;
    logic [15:0] flush_r;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            hs_valid_r <= 1'b0;
            hs_code_r <= ueb_pkg::HS_ACK;
            tx_bank_r <= 1'b0;
            flush_r <= 16'h0000;
        end else begin
            hs_valid_r <= i_tok_stb;
            if (i_tok_stb) begin
                hs_code_r <= hs_sel;
                tx_bank_r <= tok_ubank;
            end
            flush_r <= flush_v;
        end
    end

    // ************************************************
    // status read path
    // ************************************************
    wire stat_load = cmd_stb & ((cmd_op == ueb_pkg::OP_PEEK) | (cmd_op == ueb_pkg::OP_DRAIN));
    wire [7:0] stat_sel = st_w[cmd_ep];

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            wr_n_prev_r <= 1'b1;
            rd_byte_r <= ueb_pkg::STATUS_RST;
            oe_n_r <= 1'b1;
        end else begin
            wr_n_prev_r <= wr_n_s;
            if (stat_load) begin
                rd_byte_r <= stat_sel;
            end
            oe_n_r <= ~rd_drive;
        end
    end

    assign o_data = rd_byte_r;
    assign o_data_oe_n = oe_n_r;
    assign o_hs_valid = hs_valid_r;
    assign o_hs_code = hs_code_r;
    assign o_tx_bank = tx_bank_r;
    assign o_flush = flush_r;
    assign o_int_pend = pend_r;
    assign o_setup_lock = lock_r;

    // ************************************************
    // checks
    // ************************************************
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    a_stall_sets: assert property (cmd_stb && cmd_op == ueb_pkg::OP_STALL |=> halt_r[$past(cmd_ep)])
        else $error("stall command did not set halt");
    a_unstall_clears: assert property ((cmd_stb && cmd_op == ueb_pkg::OP_UNSTALL
        && !(setup_tok)) |=> !halt_r[$past(cmd_ep)])
        else $error("unstall command left halt set");
    a_setup_unstalls: assert property (setup_tok && !cmd_stb |=> !halt_r[0] && !halt_r[1])
        else $error("setup token did not unstall control endpoints");
    a_flush_toggle: assert property (flush_v[2] |=> !tog_r[2] && !full0_r[2] && !full1_r[2])
        else $error("unstall did not flush endpoint");
    a_in_sends: assert property (i_tok_stb && i_tok_kind == ueb_pkg::TOK_IN && !tok_st[7]
        && tok_full |=> o_hs_valid && o_hs_code == ueb_pkg::HS_DATA)
        else $error("validated buffer not sent on IN");
    a_out_naks: assert property (i_tok_stb && i_tok_kind == ueb_pkg::TOK_OUT && !tok_st[7]
        && tok_full |=> o_hs_code == ueb_pkg::HS_NAK)
        else $error("full OUT buffer did not NAK");
    a_peek_keeps: assert property (cmd_stb && cmd_op == ueb_pkg::OP_PEEK
        && !i_rx_ok && !i_tx_ack && !setup_tok |=> $stable(pend_r))
        else $error("snapshot read changed pending bits");
    a_peek_halt: assert property (stat_load |=> rd_byte_r[7] == $past(stat_sel[7])
        && rd_byte_r[0] == 1'b0)
        else $error("status byte halt bit wrong");
    a_lock_blocks: assert property (lock_r && cmd_stb && cmd_op == ueb_pkg::OP_VALID
        && cmd_ep == 4'h1 && !i_tx_ack |=> $stable(full0_r[1]) && $stable(cbank_r[1]))
        else $error("validate acted on locked control endpoint");
    a_clob_set: assert property (setup_tok && setp_r[0] && lock_r && !halt_r[0]
        |=> clob_r[0] [*2])
        else $error("setup setup_clobbered not flagged");
    a_rx_full: assert property (i_rx_ok && i_evt_ep == 4'h3 && !ubank_r[3]
        |=> full0_r[3])
        else $error("received packet did not set full");

    c_in_data: cover property (o_hs_valid && o_hs_code == ueb_pkg::HS_DATA);
    c_out_nak: cover property (o_hs_valid && o_hs_code == ueb_pkg::HS_NAK);
    c_clobber: cover property (clob_r[0]);
    c_dbl_swap: cover property (cbank_r[2] && full0_r[2]);

endmodule

// >>> ueb_host_model.sv
// Purpose: usb host and packet engine stand-in facing the endpoint block
// Assumes: tokens and events are one-cycle pulses on i_mclk
// Notes: released fields show their inverse so a stale value never passes
`timescale 1ns/10ps

module ueb_host_model (
    input wire logic i_mclk,
    input wire logic i_hs_valid,
    input wire logic [1:0] i_hs_code,
    output logic o_tok_stb,
    output logic [1:0] o_tok_kind,
    output logic [3:0] o_tok_ep,
    output logic o_rx_ok,
    output logic o_tx_ack,
    output logic [3:0] o_evt_ep,
    output logic o_setup_done
);
    // ************************
    // token and event drivers
    // ************************
    initial begin
        {o_tok_stb, o_rx_ok, o_tx_ack, o_setup_done} = 4'h0;
        o_tok_kind = 2'h3;
        o_tok_ep = 4'h0;
        o_evt_ep = 4'h0;
    end

    // waits a bounded time for the answer; an unknown code marks a missing one
    task automatic token(input logic [1:0] kind, input logic [3:0] ep, output logic [1:0] code);
        int k;
        @(posedge i_mclk);
        o_tok_stb <= 1'b1;
        o_tok_kind <= kind;
        o_tok_ep <= ep;
        @(posedge i_mclk);
        o_tok_stb <= 1'b0;
        o_tok_kind <= ~kind;
        o_tok_ep <= ~ep;
        k = 0;
        while (k < 4) begin
            @(posedge i_mclk);
            if (i_hs_valid === 1'b1) break;
            k++;
        end
        code = (k < 4) ? i_hs_code : 2'bxx;
    endtask

    // sel 0: good packet stored, 1: host acked in data, 2: setup stored
    task automatic evt(input logic [1:0] sel, input logic [3:0] ep);
        @(posedge i_mclk);
        o_rx_ok <= (sel == 2'h0);
        o_tx_ack <= (sel == 2'h1);
        o_setup_done <= (sel == 2'h2);
        o_evt_ep <= ep;
        @(posedge i_mclk);
        {o_rx_ok, o_tx_ack, o_setup_done} <= 3'h0;
        o_evt_ep <= ~ep;
        repeat (3) @(posedge i_mclk);
    endtask
endmodule

// >>> usb_endpoint_buffer_control_tb_top.sv
// Purpose: self-checking bench for the endpoint command block
// Assumes: firmware pins held 6 clocks around each strobe edge
// Notes: the data bus level follows whoever enables it
`timescale 1ns/10ps

module usb_endpoint_buffer_control_tb_top;
    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    logic cs_n = 1'b1, wr_n = 1'b1, rd_n = 1'b1, a0 = 1'b0;
    logic [7:0] fw_data = 8'h00;
    logic [15:0] dbl_buf = 16'h0010;
    logic [15:0] flush_seen = 16'h0000;
    logic [7:0] o_data, v;
    logic [1:0] hs, hs_code;
    logic [3:0] tok_ep, evt_ep;
    logic [1:0] tok_kind;
    logic oe_n, hs_valid, tok_stb, rx_ok, tx_ack, setup_done, tx_bank, setup_lock;
    logic [15:0] o_flush, int_pend;
    wire logic [7:0] bus = oe_n ? fw_data : o_data;
    int n_mismatch = 0, n_compared = 0, cyc = 0;

    always #5 i_mclk = ~i_mclk;

    ueb_ep_ctrl dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_cs_n(cs_n), .i_wr_n(wr_n),
        .i_rd_n(rd_n), .i_a0(a0), .i_data(bus), .o_data(o_data), .o_data_oe_n(oe_n),
        .i_dbl_buf(dbl_buf), .i_tok_stb(tok_stb), .i_tok_kind(tok_kind), .i_tok_ep(tok_ep),
        .i_rx_ok(rx_ok), .i_tx_ack(tx_ack), .i_evt_ep(evt_ep), .i_setup_done(setup_done),
        .o_hs_valid(hs_valid), .o_hs_code(hs_code), .o_tx_bank(tx_bank), .o_flush(o_flush),
        .o_int_pend(int_pend), .o_setup_lock(setup_lock));

    ueb_host_model host (.i_mclk(i_mclk), .i_hs_valid(hs_valid), .i_hs_code(hs_code),
        .o_tok_stb(tok_stb), .o_tok_kind(tok_kind), .o_tok_ep(tok_ep), .o_rx_ok(rx_ok),
        .o_tx_ack(tx_ack), .o_evt_ep(evt_ep), .o_setup_done(setup_done));

    // ************************
    // checking and closing
    // ************************
    always @(posedge i_mclk) flush_seen <= flush_seen | o_flush;

    // the whole run needs about 3100 cycles
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("mismatches %0d compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // ************************
    // firmware port access
    // ************************
    task automatic cmd(input logic [7:0] c);
        @(posedge i_mclk);
        fw_data <= c;
        a0 <= 1'b1;
        cs_n <= 1'b0;
        repeat (6) @(posedge i_mclk);
        wr_n <= 1'b0;
        repeat (6) @(posedge i_mclk);
        wr_n <= 1'b1;
        repeat (10) @(posedge i_mclk);
        cs_n <= 1'b1;
        a0 <= 1'b0;
        fw_data <= ~c;
    endtask

    task automatic rd(input logic [7:0] c, output logic [7:0] val);
        int k;
        cmd(c);
        @(posedge i_mclk);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        k = 0;
        while (oe_n !== 1'b0 && k < 20) begin
            @(posedge i_mclk);
            k++;
        end
        val = bus;
        @(posedge i_mclk);
        rd_n <= 1'b1;
        cs_n <= 1'b1;
        repeat (8) @(posedge i_mclk);
    endtask

    task automatic pk(input logic [3:0] ep, input logic [7:0] exp);
        logic [7:0] got;
        rd({ueb_pkg::OP_PEEK, ep}, got);
        check({8'h00, got}, {8'h00, exp});
    endtask

    task automatic tok(input logic [1:0] kind, input logic [3:0] ep, input logic [1:0] exp);
        host.token(kind, ep, hs);
        check({14'h0, hs}, {14'h0, exp});
    endtask

    // ************************
    // test sequence
    // ************************
    initial begin
        repeat (8) @(posedge i_mclk);
        i_rst <= 1'b0;
        @(posedge i_mclk);
        check({o_data, 7'h00, oe_n}, {ueb_pkg::STATUS_RST, 8'h01});
        for (int e = 0; e < 16; e++) begin
            cmd({ueb_pkg::OP_STALL, e[3:0]});
            pk(e[3:0], 8'h80);
            tok(ueb_pkg::TOK_IN, e[3:0], ueb_pkg::HS_STALL);
            flush_seen = 16'h0000;
            cmd({ueb_pkg::OP_UNSTALL, e[3:0]});
            pk(e[3:0], 8'h00);
            check(flush_seen, 16'h0001 << e);
        end
        cmd(8'h62);
        pk(4'h2, 8'h20);
        tok(ueb_pkg::TOK_IN, 4'h2, ueb_pkg::HS_DATA);
        host.evt(2'h1, 4'h2);
        pk(4'h2, 8'h10);
        cmd(8'h42);
        pk(4'h2, 8'h90);
        cmd(8'h82);
        pk(4'h2, 8'h00);
        host.evt(2'h0, 4'h3);
        pk(4'h3, 8'h30);
        tok(ueb_pkg::TOK_OUT, 4'h3, ueb_pkg::HS_NAK);
        cmd(8'h73);
        pk(4'h3, 8'h10);
        tok(ueb_pkg::TOK_OUT, 4'h3, ueb_pkg::HS_ACK);
        cmd(8'h64);
        pk(4'h4, 8'h22);
        cmd(8'h64);
        pk(4'h4, 8'h60);
        tok(ueb_pkg::TOK_IN, 4'h4, ueb_pkg::HS_DATA);
        check({15'h0, tx_bank}, 16'h0000);
        host.evt(2'h1, 4'h4);
        tok(ueb_pkg::TOK_IN, 4'h4, ueb_pkg::HS_DATA);
        check({15'h0, tx_bank}, 16'h0001);
        cmd(8'h40);
        cmd(8'h41);
        tok(ueb_pkg::TOK_SETUP, 4'h0, ueb_pkg::HS_ACK);
        pk(4'h1, 8'h00);
        check({15'h0, setup_lock}, 16'h0001);
        host.evt(2'h2, 4'h0);
        pk(4'h0, 8'h24);
        check({15'h0, int_pend[0]}, 16'h0001);
        cmd(8'h61);
        pk(4'h1, 8'h00);
        tok(ueb_pkg::TOK_SETUP, 4'h0, ueb_pkg::HS_ACK);
        pk(4'h0, 8'h2C);
        pk(4'h0, 8'h2C);
        host.evt(2'h2, 4'h0);
        pk(4'h0, 8'h2C);
        // firmware looks at the setup_clobbered bit before acknowledging
        rd(8'hD0, v);
        check({15'h0, v[3]}, 16'h0000);
        if (v[3] === 1'b0) begin
            cmd(ueb_pkg::CMD_ACK_SETUP);
        end
        check({15'h0, setup_lock}, 16'h0000);
        cmd(8'h61);
        pk(4'h1, 8'h20);
        cmd(8'h71);
        pk(4'h1, 8'h20);
        rd(8'h50, v);
        check({15'h0, int_pend[0]}, 16'h0000);
        cmd(8'h40);
        pk(4'h0, 8'hA4);
        stop_test();
    end
endmodule
